//--- inc/prbs_pkg.sv
// Purpose: shared constants for the pattern generator and checker
// Assumes: 40 MHz core clock, AHB-Lite register access
// Notes: pattern and state codes are the register field encodings
package prbs_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_ERR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam int ADDR_W = 8;
    // ctrl fields
    localparam int CTRL_PAT_LSB = 0;
    localparam int CTRL_PAYLOAD_BIT = 2;
    localparam int CTRL_XCONN_BIT = 3;
    localparam int CTRL_TRUNK_LSB = 4;
    localparam int CTRL_INTERNAL_ODU_PORT_LSB = 6;
    // status fields
    localparam int STAT_SYNC_LSB = 0;
    localparam int STAT_ACTIVE_BIT = 2;
    localparam int STAT_FOUND_LSB = 3;
    // interrupt bits
    localparam int IRQ_W = 3;
    localparam int IRQ_BIT_ERR = 0;
    localparam int IRQ_SYNC_CHG = 1;
    localparam int IRQ_REFUSED = 2;
    // pattern selection
    localparam logic [1:0] PRBS_OFF = 2'h0;
    localparam logic [1:0] PRBS_ORDER_ELEVEN = 2'h1;
    localparam logic [1:0] PRBS_ORDER_THIRTYONE = 2'h2;
    localparam logic [1:0] PRBS_ORDER_THIRTYONE_INVERTED = 2'h3;
    // port service states
    localparam logic [1:0] IN_SERVICE_STATE = 2'h0;
    localparam logic [1:0] OUT_OF_SERVICE_STATE = 2'h1;
    localparam logic [1:0] MAINTENANCE_SERVICE_STATE = 2'h2;
    // sync status codes
    localparam logic [1:0] PATTERN_NONE = 2'h0;
    localparam logic [1:0] PATTERN_OK = 2'h1;
    localparam logic [1:0] PATTERN_ERROR = 2'h2;
    // feedback taps, zero-based history index (x^11+x^9+1, x^31+x^28+1)
    localparam int TAP11_A = 8;
    localparam int TAP11_B = 10;
    localparam int TAP31_A = 27;
    localparam int TAP31_B = 30;
    localparam int LFSR_W = 31;
    // checker lock thresholds
    localparam int RUN_W = 7;
    localparam logic [6:0] LOCK_RUN = 7'h40;
    localparam int MISS_W = 4;
    localparam logic [3:0] LOSS_RUN = 4'h8;
    // error status hold time
    localparam int CLK_PERIOD_PS = 25000;
    localparam int ERR_HOLD_NS = 1000;
    localparam int ERR_HOLD_CYC = (ERR_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_W = 8;

    function automatic logic next_bit(input logic [1:0] kind, input logic [30:0] hist);
        case (kind)
            PRBS_ORDER_ELEVEN: return hist[TAP11_A] ^ hist[TAP11_B];
            PRBS_ORDER_THIRTYONE: return hist[TAP31_A] ^ hist[TAP31_B];
            PRBS_ORDER_THIRTYONE_INVERTED: return ~(hist[TAP31_A] ^ hist[TAP31_B]);
            default: return 1'b0;
        endcase
    endfunction : next_bit
endpackage : prbs_pkg

//--- test/prbs_generator_checker_monitor.sv
// Purpose: port checker for the pattern generator and checker
// Assumes: one clock domain, async active-high reset
// Notes: bound into the top module
`timescale 1ns/1ps
module prbs_generator_checker_monitor
    import prbs_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic [31:0] hrdata_out,
    input wire logic [1:0] sync_status_out,
    input wire logic irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic rd_q, next_rd_q;
    logic [7:0] err_len, next_err_len;
    wire take = hsel_in && htrans_in[1] && hready_in;
    always_comb begin
        next_rd_q = take && !hwrite_in;
        // saturates so a long run cannot wrap
        next_err_len = (sync_status_out != PATTERN_ERROR) ? 8'h00 :
            (err_len == 8'hFF) ? err_len : err_len + 8'h01;
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_q <= 1'b0;
            err_len <= 8'h00;
        end else begin
            rd_q <= next_rd_q;
            err_len <= next_err_len;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence rd_at(logic [7:0] a);
        take && !hwrite_in && haddr_in[7:0] == a;
    endsequence
    sequence mask_clear;
        take && hwrite_in && haddr_in[7:0] == ADDR_IRQ_MASK ##1 hwdata_in == 32'h0;
    endsequence
    ready_high_a: assert property (hreadyout_out) else $error("ready low");
    okay_resp_a: assert property (!hresp_out) else $error("resp not okay");
    sync_code_a: assert property (sync_status_out != 2'h3) else $error("bad sync code");
    read_idle_a: assert property (!rd_q |-> hrdata_out == 32'h0) else $error("stray read data");
    unmapped_zero_a: assert property (rd_at(8'h20) |=> hrdata_out == 32'h0)
        else $error("unmapped read");
    status_mirror_a: assert property (
        rd_at(ADDR_STATUS) |=> hrdata_out[1:0] == $past(sync_status_out))
        else $error("status mismatch");
    inactive_none_a: assert property (
        rd_at(ADDR_STATUS) ##1 !hrdata_out[STAT_ACTIVE_BIT] |->
        $past(sync_status_out) == PATTERN_NONE) else $error("inactive not none");
    err_hold_a: assert property (
        sync_status_out == PATTERN_OK && $past(sync_status_out) == PATTERN_ERROR |->
        err_len >= 8'h28) else $error("error released early");
    mask_quiet_a: assert property (mask_clear |-> ##[1:2] !irq_out)
        else $error("irq with no mask");
endmodule : prbs_generator_checker_monitor
bind prbs_generator_checker prbs_generator_checker_monitor prbs_generator_checker_monitor_i (
    .clk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hready_in,
    .hreadyout_out, .hresp_out, .hrdata_out, .sync_status_out, .irq_out);

//--- test/prbs_generator_checker_test.sv
// Purpose: self-checking bench for the pattern generator and checker
// Assumes: peer card model on the serial receive line
// Notes: rows cover pattern pairs, hand tests follow
`timescale 1ns/1ps
module prbs_generator_checker_test;
    import prbs_pkg::*;
    typedef struct packed {logic [1:0] pat; logic [1:0] peer; logic xc; logic [1:0] sync;} row_type;
    localparam logic [1:0] MT = MAINTENANCE_SERVICE_STATE;
    row_type rows [6] = '{'{2'h1, 2'h1, 1'b1, PATTERN_OK}, '{2'h2, 2'h2, 1'b1, PATTERN_OK},
        '{2'h3, 2'h3, 1'b1, PATTERN_OK}, '{2'h2, 2'h1, 1'b1, PATTERN_ERROR},
        '{2'h3, 2'h0, 1'b1, PATTERN_NONE}, '{2'h1, 2'h2, 1'b0, PATTERN_OK}};
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, flip = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0] htrans = 2'h0, peer_mode = 2'h0;
    logic hreadyout, hresp, tx, irq, rx, ok;
    logic [31:0] hrdata, rd;
    logic [1:0] sync;
    logic [79:0] bits;
    int err_count = 0;
    int total_checks = 0;
    always #12.5 clk_in = ~clk_in;
    prbs_generator_checker prbs_generator_checker_i (.clk_in, .rst_in,
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout), .hreadyout_out(hreadyout),
        .hresp_out(hresp), .hrdata_out(hrdata), .rx_bit_in(rx), .tx_bit_out(tx),
        .sync_status_out(sync), .irq_out(irq));
    prbs_peer_card prbs_peer_card_i (.clk_in, .rst_in, .mode_in(peer_mode),
        .flip_in(flip), .bit_out(rx));
    ////////////////////////////////////////////////////////////////////////////
    task print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict
    task check(input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic edge_ready();
        int n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            err_count++;
            print_verdict();
        end
    endtask : edge_ready
    task bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        edge_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        edge_ready();
        rd = hrdata;
    endtask : bus
    task rd_reg(input logic [7:0] a);
        bus(a, 1'b0, 32'h0);
    endtask : rd_reg
    task wr_ctrl(input logic [1:0] p, input logic pay, input logic xc,
        input logic [1:0] tr, input logic [1:0] ip);
        bus(ADDR_CTRL, 1'b1, {24'h0, ip, tr, xc, pay, p});
    endtask : wr_ctrl
    task tx_check(input logic [1:0] p);
        logic e;
        ok = 1'b1;
        for (int k = 0; k < 80; k++) begin
            @(posedge clk_in);
            bits[k] = tx;
        end
        for (int k = 31; k < 80; k++) begin
            e = (p == PRBS_ORDER_ELEVEN) ? bits[k-9] ^ bits[k-11] : bits[k-28] ^ bits[k-31];
            if (p == PRBS_ORDER_THIRTYONE_INVERTED) e = ~e;
            if (bits[k] !== e) ok = 1'b0;
        end
        if (bits == 80'h0 || &bits) ok = 1'b0; // stuck line also fits the recurrence
        check({31'h0, ok}, 32'h1);
    endtask : tx_check
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge clk_in);
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        check({26'h0, sync, irq, tx, hresp, hreadyout}, 32'h1);
        rd_reg(ADDR_CTRL);
        check(rd, 32'h0);
        rd_reg(ADDR_IRQ_MASK);
        check(rd, 32'h0);
        $display("reset test done");
        wr_ctrl(PRBS_OFF, 1'b1, 1'b0, MT, MT);
        for (int i = 0; i < 6; i++) begin
            peer_mode <= rows[i].peer;
            wr_ctrl(rows[i].pat, 1'b1, rows[i].xc, MT, MT);
            repeat (40) @(posedge clk_in);
            tx_check(rows[i].pat);
            repeat (100) @(posedge clk_in);
            rd_reg(ADDR_STATUS);
            check(rd[2:0], {1'b1, rows[i].sync});
            check(sync, rows[i].sync);
            wr_ctrl(PRBS_OFF, 1'b1, 1'b0, MT, MT);
            repeat (3) @(posedge clk_in);
            rd_reg(ADDR_ERR_COUNT);
            check(rd, 32'h0);
            $display("row %0d done", i);
        end
        peer_mode <= PRBS_ORDER_THIRTYONE;
        wr_ctrl(PRBS_ORDER_THIRTYONE, 1'b1, 1'b1, MT, MT);
        repeat (250) @(posedge clk_in);
        flip <= 1'b1;
        @(posedge clk_in);
        flip <= 1'b0;
        repeat (10) @(posedge clk_in);
        check(sync, PATTERN_ERROR);
        rd_reg(ADDR_ERR_COUNT);
        check(rd != 32'h0, 32'h1);
        rd_reg(ADDR_IRQ_STATUS);
        check(rd[IRQ_BIT_ERR], 32'h1);
        repeat (100) @(posedge clk_in);
        check(sync, PATTERN_OK);
        wr_ctrl(PRBS_OFF, 1'b1, 1'b1, MT, MT);
        repeat (3) @(posedge clk_in);
        rd_reg(ADDR_ERR_COUNT);
        check(rd, 32'h0);
        $display("error test done");
        wr_ctrl(2'h1, 1'b1, 1'b1, IN_SERVICE_STATE, OUT_OF_SERVICE_STATE);
        repeat (30) begin
            @(posedge clk_in);
            check(tx, 32'h0);
        end
        rd_reg(ADDR_STATUS);
        check(rd[2:0], {1'b0, PATTERN_NONE});
        wr_ctrl(2'h1, 1'b1, 1'b1, MT, IN_SERVICE_STATE);
        rd_reg(ADDR_CTRL);
        check(rd[7:6], MT);
        repeat (5) @(posedge clk_in);
        rd_reg(ADDR_STATUS);
        check(rd[STAT_ACTIVE_BIT], 32'h1);
        $display("state test done");
        wr_ctrl(PRBS_OFF, 1'b1, 1'b1, MT, MT);
        wr_ctrl(PRBS_OFF, 1'b0, 1'b1, MT, MT);
        bus(ADDR_IRQ_STATUS, 1'b1, 32'hFF);
        wr_ctrl(2'h1, 1'b0, 1'b1, MT, MT);
        rd_reg(ADDR_CTRL);
        check(rd[2:0], 32'h0);
        rd_reg(ADDR_IRQ_STATUS);
        check(rd[IRQ_REFUSED], 32'h1);
        wr_ctrl(PRBS_OFF, 1'b1, 1'b1, MT, MT);
        wr_ctrl(2'h1, 1'b1, 1'b1, MT, MT);
        wr_ctrl(2'h1, 1'b0, 1'b1, MT, MT);
        rd_reg(ADDR_CTRL);
        check(rd[2:0], 32'h5);
        $display("refusal test done");
        bus(ADDR_IRQ_MASK, 1'b1, 32'h4);
        repeat (3) @(posedge clk_in);
        check(irq, 32'h1);
        bus(ADDR_IRQ_STATUS, 1'b1, 32'hFF);
        repeat (3) @(posedge clk_in);
        check(irq, 32'h0);
        rd_reg(ADDR_IRQ_MASK);
        check(rd, 32'h4);
        bus(8'h20, 1'b1, 32'hFFFF);
        rd_reg(8'h20);
        check(rd, 32'h0);
        bus(ADDR_IRQ_MASK, 1'b1, 32'h0);
        repeat (3) @(posedge clk_in);
        $display("interrupt test done");
        print_verdict();
    end
endmodule : prbs_generator_checker_test

//--- test/prbs_peer_card.sv
// Purpose: peer card model sending one pattern bit per clock
// Assumes: shares the core clock of the block under test
// Notes: flip_in corrupts one bit without upsetting the sequence
`timescale 1ns/1ps
module prbs_peer_card
    import prbs_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [1:0] mode_in,
    input wire logic flip_in,
    output logic bit_out
);
    logic [30:0] hist, next_hist;
    logic next_bit_out, fb;
    always_comb begin
        fb = (mode_in == PRBS_ORDER_ELEVEN) ? hist[8] ^ hist[10] : hist[27] ^ hist[30];
        next_hist = {hist[29:0], fb};
        next_bit_out = ((mode_in == PRBS_ORDER_THIRTYONE_INVERTED) ? ~fb : fb) ^ flip_in;
        if (mode_in == PRBS_OFF) begin
            next_hist = hist;
            next_bit_out = ~bit_out; // no pattern: line keeps changing
        end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            hist <= '1;
            bit_out <= 1'b0;
        end else begin
            hist <= next_hist;
            bit_out <= next_bit_out;
        end
    end
endmodule : prbs_peer_card

//--- verilog/prbs_generator_checker.sv
// Purpose: pattern generator and checker on one internal ODU port
// Assumes: AHB-Lite single word transfers, 40 MHz core clock
// Notes: one serial bit per clock each way; rx comes from the peer card
//
// Notes on behaviour
// [R1] Patterns are off, order 11, order 31 or inverted order 31.
// [R2] Generation and checking run only in maintenance, else forced off.
// [R3] Putting the trunk ports into maintenance moves the internal port there too.
// [R4] The status reads ok while a recognised pattern arrives without errors.
// [R5] The status reads error on bit errors or a pattern other than the setting.
// [R6] The status reads none while no recognised pattern arrives.
// [R7] An error counter counts errors and clears when the function is off.
// [R8] The peer must send the same pattern as configured here for a valid result.
// [R9] Enabling needs a provisioned payload, and payload changes are refused while enabled.
// [R10] With no cross-connection or client the status reads ok despite any mismatch.
// [R11] Order 11 uses x^11+x^9+1, order 31 uses x^31+x^28+1, inverted flips order 31.
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
module prbs_generator_checker (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    input wire logic rx_bit_in,
    output logic tx_bit_out,
    output logic [1:0] sync_status_out,
    output logic irq_out
);
    import prbs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // signals

    logic [1:0] pattern;
    logic [1:0] next_pattern;
    logic payload;
    logic next_payload;
    logic xconn;
    logic next_xconn;
    logic [1:0] trunk_state;
    logic [1:0] next_trunk_state;
    logic [1:0] internal_odu_port_state;
    logic [1:0] next_internal_odu_port_state;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] next_irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] next_irq_mask;
    logic next_irq;

    logic wr_pend;
    logic next_wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [ADDR_W-1:0] next_wr_addr;
    logic [31:0] next_hrdata;
    logic refused;
    logic [1:0] w_pattern;
    logic w_payload;
    logic [1:0] w_trunk;

    logic rx_meta;
    logic rx_sync;
    logic gen_bit;
    logic active;
    logic [1:0] eff_mode;
    logic [1:0] found;
    logic bit_err;

    logic [1:0] sync_status;
    logic [1:0] next_sync;
    logic [31:0] err_count;
    logic [31:0] next_err_count;
    logic [HOLD_W-1:0] hold;
    logic [HOLD_W-1:0] next_hold;

    ////////////////////////////////////////////////////////////////////////
    // rx pin synchroniser

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_meta <= 1'b0;
            rx_sync <= 1'b0;
        end else begin
            rx_meta <= rx_bit_in;
            rx_sync <= rx_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pattern engines

    always_comb begin
        // register keeps the setting; the engines see off outside maintenance
        active = (internal_odu_port_state == MAINTENANCE_SERVICE_STATE) && (pattern != PRBS_OFF); // [R2]
        eff_mode = active ? pattern : PRBS_OFF; // [R2]
    end

    prbs_pattern_source u_source (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .mode_in(eff_mode),
        .bit_out(gen_bit)
    );

    prbs_pattern_monitor u_monitor (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .rx_bit_in(rx_sync),
        .active_in(active),
        .cfg_in(eff_mode),
        .found_out(found),
        .bit_err_out(bit_err)
    );

    ////////////////////////////////////////////////////////////////////////
    // sync status and error counter

    always_comb begin
        next_hold = hold;
        if (!active) begin
            next_hold = '0;
        end else if (bit_err) begin
            // hold error briefly so a lone bit error is visible to software
            next_hold = HOLD_W'(ERR_HOLD_CYC);
        end else if (hold != '0) begin
            next_hold = hold - 1'b1;
        end

        if (!active) begin
            next_sync = PATTERN_NONE;
        end else if (!xconn) begin
            next_sync = PATTERN_OK; // [R10]
        end else if (found == PRBS_OFF) begin
            next_sync = PATTERN_NONE; // [R6]
        end else if (found != eff_mode) begin
            next_sync = PATTERN_ERROR; // [R5]
        end else if (bit_err || hold != '0) begin
            next_sync = PATTERN_ERROR; // [R5]
        end else begin
            next_sync = PATTERN_OK; // [R4]
        end

        if (!active) begin
            next_err_count = '0; // [R7]
        end else if (bit_err && err_count != '1) begin
            next_err_count = err_count + 1'b1; // [R7]
        end else begin
            next_err_count = err_count;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            hold <= '0;
            sync_status <= PATTERN_NONE;
            err_count <= '0;
        end else begin
            hold <= next_hold;
            sync_status <= next_sync;
            err_count <= next_err_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave, zero wait states, always okay

    always_comb begin
        next_wr_pend = 1'b0;
        next_wr_addr = wr_addr;
        next_hrdata = '0;
        if (hsel_in && htrans_in[1] && hready_in) begin
            next_wr_pend = hwrite_in;
            next_wr_addr = haddr_in[ADDR_W-1:0];
            if (!hwrite_in) begin
                case (haddr_in[ADDR_W-1:0])
                    ADDR_CTRL: begin
                        next_hrdata[CTRL_PAT_LSB +: 2] = pattern;
                        next_hrdata[CTRL_PAYLOAD_BIT] = payload;
                        next_hrdata[CTRL_XCONN_BIT] = xconn;
                        next_hrdata[CTRL_TRUNK_LSB +: 2] = trunk_state;
                        next_hrdata[CTRL_INTERNAL_ODU_PORT_LSB +: 2] = internal_odu_port_state;
                    end
                    ADDR_STATUS: begin
                        next_hrdata[STAT_SYNC_LSB +: 2] = sync_status;
                        next_hrdata[STAT_ACTIVE_BIT] = active;
                        next_hrdata[STAT_FOUND_LSB +: 2] = found;
                    end
                    ADDR_ERR_COUNT: next_hrdata = err_count;
                    ADDR_IRQ_STATUS: next_hrdata[IRQ_W-1:0] = irq_status;
                    ADDR_IRQ_MASK: next_hrdata[IRQ_W-1:0] = irq_mask;
                    default: next_hrdata = '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers

    always_comb begin
        next_pattern = pattern;
        next_payload = payload;
        next_xconn = xconn;
        next_trunk_state = trunk_state;
        next_internal_odu_port_state = internal_odu_port_state;
        next_irq_mask = irq_mask;
        refused = 1'b0;
        w_pattern = hwdata_in[CTRL_PAT_LSB +: 2];
        w_payload = hwdata_in[CTRL_PAYLOAD_BIT];
        w_trunk = hwdata_in[CTRL_TRUNK_LSB +: 2];
        if (wr_pend && wr_addr == ADDR_CTRL) begin
            next_pattern = w_pattern; // [R1]
            if (pattern == PRBS_OFF && w_pattern != PRBS_OFF && !payload) begin
                next_pattern = PRBS_OFF; // [R9]
                refused = 1'b1;
            end
            next_payload = w_payload;
            if (pattern != PRBS_OFF && w_payload != payload) begin
                next_payload = payload; // [R9]
                refused = 1'b1;
            end
            next_xconn = hwdata_in[CTRL_XCONN_BIT];
            next_trunk_state = w_trunk;
            next_internal_odu_port_state = hwdata_in[CTRL_INTERNAL_ODU_PORT_LSB +: 2];
            if (w_trunk == MAINTENANCE_SERVICE_STATE) begin
                next_internal_odu_port_state = MAINTENANCE_SERVICE_STATE; // [R3]
            end
        end
        if (wr_pend && wr_addr == ADDR_IRQ_MASK) begin
            next_irq_mask = hwdata_in[IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: sticky, write one to clear, set wins

    always_comb begin
        next_irq_status = irq_status;
        if (wr_pend && wr_addr == ADDR_IRQ_STATUS) begin
            next_irq_status = irq_status & ~hwdata_in[IRQ_W-1:0];
        end
        next_irq_status[IRQ_BIT_ERR] = next_irq_status[IRQ_BIT_ERR] | bit_err;
        next_irq_status[IRQ_SYNC_CHG] = next_irq_status[IRQ_SYNC_CHG] | (next_sync != sync_status);
        next_irq_status[IRQ_REFUSED] = next_irq_status[IRQ_REFUSED] | refused;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pattern <= PRBS_OFF;
            payload <= 1'b0;
            xconn <= 1'b0;
            trunk_state <= IN_SERVICE_STATE;
            internal_odu_port_state <= IN_SERVICE_STATE;
            irq_status <= '0;
            irq_mask <= '0;
            wr_pend <= 1'b0;
            wr_addr <= '0;
            hrdata_out <= '0;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            tx_bit_out <= 1'b0;
            sync_status_out <= PATTERN_NONE;
            irq_out <= 1'b0;
        end else begin
            pattern <= next_pattern;
            payload <= next_payload;
            xconn <= next_xconn;
            trunk_state <= next_trunk_state;
            internal_odu_port_state <= next_internal_odu_port_state;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata_out <= next_hrdata;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            tx_bit_out <= gen_bit; // [R1]
            sync_status_out <= next_sync;
            irq_out <= next_irq;
        end
    end
endmodule : prbs_generator_checker

//--- verilog/prbs_pattern_monitor.sv
// Purpose: self-synchronising checker that hunts all three patterns
// Assumes: rx_bit_in already synchronised to clk_in
// Notes: lock after a run of matches, loss after a run of misses
`timescale 1ns/1ps
module prbs_pattern_monitor (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic rx_bit_in,
    input wire logic active_in,
    input wire logic [1:0] cfg_in,
    output logic [1:0] found_out,
    output logic bit_err_out
);
    import prbs_pkg::*;

    logic [LFSR_W-1:0] hist;
    logic [LFSR_W-1:0] next_hist;
    logic [RUN_W-1:0] run [3:1];
    logic [RUN_W-1:0] next_run [3:1];
    logic [MISS_W-1:0] miss [3:1];
    logic [MISS_W-1:0] next_miss [3:1];
    logic [3:1] lock;
    logic [3:1] next_lock;
    logic [3:1] hit;

    always_comb begin
        next_hist = {hist[LFSR_W-2:0], rx_bit_in};
        found_out = PRBS_OFF;
        for (int k = 1; k <= 3; k++) begin
            hit[k] = (next_bit(2'(k), hist) == rx_bit_in);
            next_run[k] = run[k];
            next_miss[k] = miss[k];
            next_lock[k] = lock[k];
            if (!active_in) begin
                next_run[k] = '0;
                next_miss[k] = '0;
                next_lock[k] = 1'b0;
            end else if (hit[k]) begin
                next_miss[k] = '0;
                if (run[k] != LOCK_RUN) begin
                    next_run[k] = run[k] + 1'b1;
                end
                if (next_run[k] == LOCK_RUN) begin
                    next_lock[k] = 1'b1;
                end
            end else begin
                next_run[k] = '0;
                if (miss[k] != LOSS_RUN) begin
                    next_miss[k] = miss[k] + 1'b1;
                end
                if (next_miss[k] == LOSS_RUN) begin
                    next_lock[k] = 1'b0;
                end
            end
        end
        // any recognised pattern is reported, the configured one first
        for (int k = 3; k >= 1; k--) begin
            if (lock[k]) begin
                found_out = 2'(k);
            end
        end
        if (cfg_in != PRBS_OFF && lock[cfg_in]) begin
            found_out = cfg_in;
        end
        bit_err_out = active_in && cfg_in != PRBS_OFF && lock[cfg_in] && !hit[cfg_in]; // [R5]
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            hist <= '0;
            lock <= '0;
            for (int k = 1; k <= 3; k++) begin
                run[k] <= '0;
                miss[k] <= '0;
            end
        end else begin
            hist <= next_hist;
            lock <= next_lock;
            for (int k = 1; k <= 3; k++) begin
                run[k] <= next_run[k];
                miss[k] <= next_miss[k];
            end
        end
    end
endmodule : prbs_pattern_monitor

//--- verilog/prbs_pattern_source.sv
// Purpose: serial pseudo-random pattern source, one bit per clock
// Assumes: mode_in is already forced off outside maintenance
// Notes: inverted mode runs the order-31 register and flips the output
`timescale 1ns/1ps
module prbs_pattern_source (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [1:0] mode_in,
    output logic bit_out
);
    import prbs_pkg::*;

    logic [LFSR_W-1:0] lfsr;
    logic [LFSR_W-1:0] next_lfsr;
    logic core_bit;
    logic [1:0] core_kind;

    always_comb begin
        core_kind = (mode_in == PRBS_ORDER_THIRTYONE_INVERTED) ? PRBS_ORDER_THIRTYONE : mode_in;
        core_bit = next_bit(core_kind, lfsr);
        if (mode_in == PRBS_OFF) begin
            // reseed so every enable starts from a known non-zero state
            next_lfsr = '1;
            bit_out = 1'b0;
        end else begin
            next_lfsr = {lfsr[LFSR_W-2:0], core_bit};
            bit_out = (mode_in == PRBS_ORDER_THIRTYONE_INVERTED) ? ~core_bit : core_bit; // [R11]
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lfsr <= '1;
        end else begin
            lfsr <= next_lfsr;
        end
    end
endmodule : prbs_pattern_source
